/* hdl/kpm_mux.sv */
// Keypad port pin-function multiplexer with GPIO fallback and debug-event pulse.
`timescale 1ns/1ps
`default_nettype none

module kpm_mux
    import kpm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire kpm_pkg::kpm_cfg_t cfg,
    input wire logic pin_set_select,
    input wire logic [7:0] col_i,
    output logic [7:0] col_o,
    output logic [7:0] col_oe,
    input wire logic [6:0] row_i,
    output logic [6:0] row_o,
    output logic [6:0] row_oe,
    input wire logic [5:0] keypad_column_strobe_lower,
    input wire logic keypad_column_strobe_six,
    input wire logic keypad_column_strobe_seven,
    input wire logic timer_one_compare_out,
    input wire logic pwm_out,
    output logic [4:0] keypad_row_sense_lower,
    output logic keypad_row_sense_five,
    output logic keypad_row_sense_six,
    output logic timer_capture_two_in,
    input wire logic codec_frame_sync_alt_o,
    input wire logic codec_frame_sync_alt_oe,
    input wire logic primary_frame_sync_i,
    output logic codec_tx_frame_sync,
    output logic codec_rx_frame_sync,
    input wire logic primary_debug_event_n_i,
    input wire logic debug_entry,
    output logic debug_request,
    output logic [14:0] gpio_in
);
    import kpm_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [17:0] sync_m;
    logic [17:0] sync_s;
    logic [7:0] col_s;
    logic [6:0] row_s;
    logic set_alt;
    logic [7:0] strobe;
    logic [1:0] dbg_cnt;
    logic dbg_drive;
    logic [1:0] oe_echo;
    logic [7:0] next_col_o;
    logic [7:0] next_col_oe;
    logic [6:0] next_row_o;
    logic [6:0] next_row_oe;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync_m <= SYNC_RST;
            sync_s <= SYNC_RST;
        end
        else
        begin
            sync_m <= {pin_set_select, primary_frame_sync_i, primary_debug_event_n_i,
                       row_i, col_i};
            sync_s <= sync_m;
        end
    end

    assign col_s = sync_s[SYNC_COL_LSB +: N_COL];
    assign row_s = sync_s[SYNC_ROW_LSB +: N_ROW];
    assign set_alt = sync_s[SYNC_SET];
    assign strobe = {keypad_column_strobe_seven, keypad_column_strobe_six,
                     keypad_column_strobe_lower};

    // ************************************************************
    // Drive helpers
    // ************************************************************
    // Open-drain strobes only ever pull low; the pull-up gives the high level.
    function automatic kpm_pin_t strobe_drive(input logic val, input logic od);
        kpm_pin_t p;
        if (od)
        begin
            p.o = 1'b0;
            p.oe = ~val;
        end
        else
        begin
            p.o = val;
            p.oe = 1'b1;
        end
        return p;
    endfunction

    function automatic kpm_pin_t push_pull(input logic val);
        kpm_pin_t p;
        p.o = val;
        p.oe = 1'b1;
        return p;
    endfunction

    // ************************************************************
    // Debug-event pulse
    // ************************************************************
    // A new entry during a running pulse is ignored, keeping the pulse length exact.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            dbg_cnt <= 2'h0;
        else if (dbg_cnt != 2'h0)
            dbg_cnt <= dbg_cnt - 2'h1;
        else if (debug_entry)
            dbg_cnt <= DBG_PULSE_CYCLES;
    end

    assign dbg_drive = (dbg_cnt != 2'h0);

    // The pin level returns through the synchroniser two cycles late, so the
    // read-back mask must outlast our own drive by that much.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            oe_echo <= 2'h0;
        else
            oe_echo <= {oe_echo[0], row_oe[ROW_SIX]};
    end

    // ************************************************************
    // Output function selection
    // ************************************************************
    always_comb
    begin
        kpm_pin_t p;
        p = '0;
        next_col_o = '0;
        next_col_oe = '0;
        next_row_o = '0;
        next_row_oe = '0;
        for (int i = 0; i < N_COL; i++)
        begin
            p.o = cfg.gpio_out[i];
            p.oe = cfg.gpio_dir[i];
            if (cfg.col_strobe_en[i])
                p = strobe_drive(strobe[i], cfg.col_open_drain[i]);
            else if (i == COL_SIX && cfg.keypad_column_strobe_six_compare_sel)
                p = push_pull(timer_one_compare_out);
            else if (i == COL_SEVEN && cfg.keypad_column_strobe_seven_pwm_sel)
                p = push_pull(pwm_out);
            next_col_o[i] = p.o;
            next_col_oe[i] = p.oe;
        end
        for (int j = 0; j < N_ROW; j++)
        begin
            p.o = cfg.gpio_out[GPIO_ROW_BASE + j];
            p.oe = cfg.gpio_dir[GPIO_ROW_BASE + j];
            if (j == ROW_SIX && set_alt)
            begin
                p.o = 1'b0;
                p.oe = dbg_drive;
            end
            else if (cfg.row_sense_en[j])
                p = '0;
            else if (j == ROW_FIVE && cfg.keypad_row_sense_five_capture_sel)
                p = '0;
            else if (j == ROW_SIX && cfg.keypad_row_sense_six_frame_sync_sel)
            begin
                p.o = codec_frame_sync_alt_o;
                p.oe = codec_frame_sync_alt_oe;
            end
            next_row_o[j] = p.o;
            next_row_oe[j] = p.oe;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            col_o <= 8'h00;
            col_oe <= 8'h00;
            row_o <= 7'h00;
            row_oe <= 7'h00;
        end
        else
        begin
            col_o <= next_col_o;
            col_oe <= next_col_oe;
            row_o <= next_row_o;
            row_oe <= next_row_oe;
        end
    end

    // ************************************************************
    // Input routing
    // ************************************************************
    // Row senses idle high when the pin is taken by another function.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            gpio_in <= 15'h0000;
            keypad_row_sense_lower <= 5'h1f;
            keypad_row_sense_five <= 1'b1;
            keypad_row_sense_six <= 1'b1;
            timer_capture_two_in <= 1'b0;
            codec_tx_frame_sync <= 1'b0;
            codec_rx_frame_sync <= 1'b0;
            debug_request <= 1'b0;
        end
        else
        begin
            gpio_in <= {row_s, col_s};
            for (int k = 0; k < 5; k++)
                keypad_row_sense_lower[k] <= cfg.row_sense_en[k] ? row_s[k] : 1'b1;
            keypad_row_sense_five <= cfg.row_sense_en[ROW_FIVE] ? row_s[ROW_FIVE] : 1'b1;
            keypad_row_sense_six <= (cfg.row_sense_en[ROW_SIX] && !set_alt)
                                    ? row_s[ROW_SIX] : 1'b1;
            timer_capture_two_in <= cfg.keypad_row_sense_five_capture_sel && !cfg.row_sense_en[ROW_FIVE]
                                    && row_s[ROW_FIVE];
            if (cfg.keypad_row_sense_six_frame_sync_sel && !set_alt)
            begin
                codec_tx_frame_sync <= row_s[ROW_SIX];
                codec_rx_frame_sync <= cfg.codec_sync_mode && row_s[ROW_SIX];
            end
            else
            begin
                codec_tx_frame_sync <= sync_s[SYNC_FS];
                codec_rx_frame_sync <= sync_s[SYNC_FS];
            end
            // Our own pulse on the pin must not read back as a new request.
            if (set_alt)
                debug_request <= !row_s[ROW_SIX] && !dbg_drive && !row_oe[ROW_SIX]
                                 && (oe_echo == 2'h0);
            else
                debug_request <= !sync_s[SYNC_DBG_N];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_reset_pins_off: assert property (@(posedge clk)
        !rst_n |=> (col_oe == 8'h00) && (row_oe == 7'h00))
        else $error("pin driver on after reset");

    a_strobe_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.col_strobe_en[0] && cfg.col_open_drain[0]
        |=> !col_o[0] && (col_oe[0] == !$past(keypad_column_strobe_lower[0])))
        else $error("open-drain strobe drives wrong level");

    a_gpio_fallback: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg.col_strobe_en[1] |=> (col_oe[1] == $past(cfg.gpio_dir[1]))
        && (col_o[1] == $past(cfg.gpio_out[1])))
        else $error("column one not following GPIO settings");

    a_keypad_column_strobe_six_compare: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg.col_strobe_en[6] && cfg.keypad_column_strobe_six_compare_sel
        |=> col_oe[6] && (col_o[6] == $past(timer_one_compare_out)))
        else $error("column six not carrying compare output");

    a_keypad_column_strobe_seven_pwm: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg.col_strobe_en[7] && cfg.keypad_column_strobe_seven_pwm_sel
        |=> col_oe[7] && (col_o[7] == $past(pwm_out)))
        else $error("column seven not carrying pulse-width output");

    a_row_sense_input: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.row_sense_en[0] |=> !row_oe[0])
        else $error("row sense pin is driving");

    a_sync_fs_both: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.keypad_row_sense_six_frame_sync_sel && cfg.codec_sync_mode && !set_alt
        |=> codec_rx_frame_sync == codec_tx_frame_sync)
        else $error("synchronous frame sync differs between directions");

    a_primary_fs_cut: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.keypad_row_sense_six_frame_sync_sel && !cfg.codec_sync_mode && !set_alt
        |=> !codec_rx_frame_sync)
        else $error("primary frame sync leaks into codec");

    a_debug_pulse_len: assert property (@(posedge clk) disable iff (!rst_n)
        set_alt && debug_entry && !dbg_drive ##1 set_alt[*4]
        |-> $past(row_oe[6], 3) == 1'b0 && row_oe[6] && $past(row_oe[6])
        && $past(row_oe[6], 2) ##1 !row_oe[6])
        else $error("debug-event pulse not three cycles");

    a_debug_src_alt: assert property (@(posedge clk) disable iff (!rst_n)
        set_alt && !dbg_drive && !row_oe[6] && row_s[6] |=> !debug_request)
        else $error("primary debug pin reached debug logic");

    c_open_drain_strobe: cover property (@(posedge clk) disable iff (!rst_n)
        cfg.col_strobe_en[0] && cfg.col_open_drain[0] && col_oe[0]);
    c_debug_pulse: cover property (@(posedge clk) disable iff (!rst_n)
        set_alt && $rose(row_oe[6]));
    c_alt_frame_sync: cover property (@(posedge clk) disable iff (!rst_n)
        cfg.keypad_row_sense_six_frame_sync_sel && !set_alt && codec_tx_frame_sync);

endmodule

`default_nettype wire

/* inc/kpm_pkg.sv */
// Shared constants and carrier types for the keypad port pin-function multiplexer.
package kpm_pkg;

    // ************************************************************
    // Pin counts and indices
    // ************************************************************
    localparam int N_COL = 8;
    localparam int N_ROW = 7;
    localparam int N_GPIO = 15;
    localparam int COL_SIX = 6;
    localparam int COL_SEVEN = 7;
    localparam int ROW_FIVE = 5;
    localparam int ROW_SIX = 6;
    localparam int GPIO_ROW_BASE = 8;

    // ************************************************************
    // Synchroniser layout and reset value
    // ************************************************************
    localparam int SYNC_W = 18;
    localparam int SYNC_COL_LSB = 0;
    localparam int SYNC_ROW_LSB = 8;
    localparam int SYNC_DBG_N = 15;
    localparam int SYNC_FS = 16;
    localparam int SYNC_SET = 17;
    // The primary debug-event pin idles high, so its stage resets high.
    localparam logic [17:0] SYNC_RST = 18'h08000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam logic [1:0] DBG_PULSE_CYCLES = 2'h3;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [7:0] col_strobe_en;
        logic [7:0] col_open_drain;
        logic keypad_column_strobe_six_compare_sel;
        logic keypad_column_strobe_seven_pwm_sel;
        logic [6:0] row_sense_en;
        logic keypad_row_sense_five_capture_sel;
        logic keypad_row_sense_six_frame_sync_sel;
        logic codec_sync_mode;
        logic [14:0] gpio_dir;
        logic [14:0] gpio_out;
    } kpm_cfg_t;

    typedef struct packed {
        logic o;
        logic oe;
    } kpm_pin_t;

endpackage

/* verification/kpm_keypad_model.sv */
// Model of the keypad matrix and debug command converter on the far side of the pins.
`timescale 1ns/1ps
`default_nettype none

module kpm_keypad_model (
    input wire logic clk,
    input wire logic [7:0] col_o,
    input wire logic [7:0] col_oe,
    input wire logic [6:0] row_o,
    input wire logic [6:0] row_oe,
    input wire logic [7:0] col_ext,
    input wire logic key_on,
    input wire logic [2:0] key_col,
    input wire logic [2:0] key_row,
    input wire logic dbg_pull,
    input wire logic keypad_row_sense_six_pull_up,
    output logic [7:0] col_i,
    output logic [6:0] row_i
);
    logic tog = 1'b0;

    // Row five has no on-chip pull-up; the matrix holds it high while the keypad
    // is in use, and otherwise the floating level keeps changing.
    always_ff @(posedge clk)
    begin
        tog <= ~tog;
    end

    always_comb
    begin
        col_i = (col_oe & col_o) | (~col_oe & col_ext);
        for (int r = 0; r < 7; r++)
        begin
            if (row_oe[r])
                row_i[r] = row_o[r];
            else if (r == 6 && dbg_pull)
                row_i[r] = 1'b0;
            else if (key_on && key_row == r && col_oe[key_col])
                row_i[r] = col_o[key_col];
            else if (r < 5)
                row_i[r] = 1'b1;
            else if (r == 5 && key_on)
                row_i[r] = 1'b1;
            else
                row_i[r] = (r == 6) ? keypad_row_sense_six_pull_up : tog;
        end
    end
endmodule

`default_nettype wire

/* verification/testbench.sv */
// Self-checking testbench for the keypad port pin-function multiplexer.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import kpm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    kpm_cfg_t cfg = '1;
    logic pss = 1'b0;
    logic [7:0] col_i, col_o, col_oe, col_ext = 8'h00;
    logic [6:0] row_i, row_o, row_oe;
    logic [5:0] ks_lo = 6'h00;
    logic ks6 = 1'b0, ks7 = 1'b0, oc = 1'b0, pwm = 1'b0, fs_o = 1'b0, fs_oe = 1'b0;
    logic pfs = 1'b0, pdbg_n = 1'b1, dbg_entry = 1'b0;
    logic [4:0] sense_lo;
    logic s5, s6, cap, ctx, crx, dbg_req;
    logic [14:0] gpio_in;
    logic key_on = 1'b0, dbg_pull = 1'b0;
    logic [2:0] key_col = 3'h0, key_row = 3'h0;
    int bad_count = 0;
    int n_checks = 0;
    int cnt;
    int echo;
    logic [63:0] r;
    logic [1:0] er;

    initial forever #50 clk = ~clk;

    kpm_mux u_dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .pin_set_select(pss),
        .col_i(col_i), .col_o(col_o), .col_oe(col_oe), .row_i(row_i), .row_o(row_o),
        .row_oe(row_oe), .keypad_column_strobe_lower(ks_lo), .keypad_column_strobe_six(ks6),
        .keypad_column_strobe_seven(ks7), .timer_one_compare_out(oc), .pwm_out(pwm),
        .keypad_row_sense_lower(sense_lo), .keypad_row_sense_five(s5),
        .keypad_row_sense_six(s6), .timer_capture_two_in(cap),
        .codec_frame_sync_alt_o(fs_o), .codec_frame_sync_alt_oe(fs_oe),
        .primary_frame_sync_i(pfs), .codec_tx_frame_sync(ctx), .codec_rx_frame_sync(crx),
        .primary_debug_event_n_i(pdbg_n), .debug_entry(dbg_entry),
        .debug_request(dbg_req), .gpio_in(gpio_in));

    kpm_keypad_model u_pad (.clk(clk), .col_o(col_o), .col_oe(col_oe), .row_o(row_o),
        .row_oe(row_oe), .col_ext(col_ext), .key_on(key_on), .key_col(key_col),
        .key_row(key_row), .dbg_pull(dbg_pull), .keypad_row_sense_six_pull_up(pss), .col_i(col_i),
        .row_i(row_i));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Expected {o, oe} of a column: strobe first, then timer or pwm, then GPIO.
    function automatic logic [1:0] exp_col(input int i);
        logic s;
        s = (i < 6) ? ks_lo[i] : ((i == 6) ? ks6 : ks7);
        if (cfg.col_strobe_en[i])
            return cfg.col_open_drain[i] ? {1'b0, ~s} : {s, 1'b1};
        if (i == 6 && cfg.keypad_column_strobe_six_compare_sel)
            return {oc, 1'b1};
        if (i == 7 && cfg.keypad_column_strobe_seven_pwm_sel)
            return {pwm, 1'b1};
        return {cfg.gpio_out[i], cfg.gpio_dir[i]};
    endfunction

    function automatic logic [1:0] exp_row(input int j);
        if (cfg.row_sense_en[j] || (j == 5 && cfg.keypad_row_sense_five_capture_sel))
            return 2'b00;
        if (j == 6 && cfg.keypad_row_sense_six_frame_sync_sel)
            return {fs_o, fs_oe};
        return {cfg.gpio_out[8 + j], cfg.gpio_dir[8 + j]};
    endfunction

    initial
    begin
        #2000000;
        bad_count++;
        $display("[FAIL] %0t run did not finish", $time);
        complete_run();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'ha04d));
        cyc(4);
        chk(col_oe === 8'h00 && row_oe === 7'h00 && gpio_in === 15'h0000, "reset drive");
        chk({s6, s5, sense_lo} === 7'h7f && {cap, ctx, crx, dbg_req} === 4'h0, "reset");
        cyc(2);
        rst_n = 1'b1;
        $display("test reset done");
        for (int k = 0; k < 300; k++)
        begin
            r = {$urandom(), $urandom()};
            cfg = kpm_cfg_t'(r[57:0]);
            {ks_lo, ks6, ks7, oc, pwm, fs_o, fs_oe} = 12'($urandom());
            cyc(1);
            for (int i = 0; i < 8; i++)
                chk({col_o[i], col_oe[i]} === exp_col(i), "column drive");
            for (int j = 0; j < 7; j++)
            begin
                er = exp_row(j);
                chk(row_oe[j] === er[0] && (!row_oe[j] || row_o[j] === er[1]),
                    "row drive");
            end
        end
        $display("test random drive done");
        cfg = '0;
        col_ext = 8'($urandom());
        cyc(6);
        chk(gpio_in[12:0] === {5'h1f, col_ext} && gpio_in[14] === 1'b0, "gpio input");
        cfg.row_sense_en = 7'h3f;
        cfg.col_strobe_en = 8'h3f;
        cfg.col_open_drain = 8'h3f;
        key_on = 1'b1;
        ks_lo = 6'h00;
        for (int j = 0; j < 6; j++)
        begin
            key_col = 3'($urandom_range(5));
            key_row = 3'(j);
            cyc(6);
            chk({s6, s5, sense_lo} === {1'b1, ~(6'h01 << j)}, "row sense");
        end
        cfg.row_sense_en = 7'h00;
        cfg.keypad_row_sense_five_capture_sel = 1'b1;
        cfg.col_open_drain = 8'h00;
        for (int v = 0; v < 2; v++)
        begin
            ks_lo = {6{v[0]}};
            cyc(6);
            chk(cap === v[0] && s5 === 1'b1, "capture input");
        end
        $display("test input paths done");
        cfg = '0;
        cfg.col_strobe_en = 8'h01;
        cfg.keypad_row_sense_six_frame_sync_sel = 1'b1;
        key_col = 3'h0;
        key_row = 3'h6;
        pfs = 1'b1;
        fs_oe = 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            cfg.codec_sync_mode = m[1];
            ks_lo[0] = m[0];
            cyc(6);
            chk(ctx === m[0] && crx === (m[1] & m[0]), "frame sync");
        end
        $display("test frame sync done");
        key_on = 1'b0;
        for (int a = 0; a < 2; a++)
        begin
            pss = a[0];
            cfg = '0;
            cfg.gpio_dir[14] = 1'b1;
            cfg.gpio_out[14] = 1'b1;
            cyc(6);
            chk(row_oe[6] === !a[0] && (a[0] || row_o[6] === 1'b1), "row six owner");
            cfg.gpio_dir[14] = 1'b0;
            dbg_entry = 1'b1;
            cnt = 0;
            echo = 0;
            for (int t = 0; t < 12; t++)
            begin
                cyc(1);
                dbg_entry = (t == 1);
                if (row_oe[6] === 1'b1 && row_o[6] === 1'b0)
                    cnt++;
                if (dbg_req !== 1'b0)
                    echo++;
            end
            chk(cnt == 3 * a, "debug pulse length");
            chk(echo == 0, "own pulse read back as request");
            dbg_pull = 1'b1;
            cyc(6);
            chk(dbg_req === a[0], "converter request");
            dbg_pull = 1'b0;
            pdbg_n = 1'b0;
            cyc(6);
            chk(dbg_req === !a[0], "primary request");
            pdbg_n = 1'b1;
        end
        $display("test debug event done");
        complete_run();
    end
endmodule

`default_nettype wire
